// ==== rtl/byte_op_pkg.sv ====
// Constants, opcodes, register map and field layout for the byte-op core.
// Assumes a single 125 MHz clock and an AHB-Lite register port.
package byte_op_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int DATA_W = 8;      // File register and accumulator
  localparam int FADDR_W = 7;     // File register operand
  localparam int PC_W = 13;       // Program counter
  localparam int INSTR_W = 14;    // Instruction word
  localparam int OPC_W = 6;       // Opcode field
  localparam int SP_W = 3;        // Stack pointer (eight levels)

  // ----------------------------------------------------------------
  // Instruction fields
  // ----------------------------------------------------------------
  localparam int OPC_LSB = 8;     // Opcode in bits 13:8
  localparam int DEST_BIT = 7;    // Destination select
  localparam logic DEST_ACC = 1'b0;   // Result to accumulator
  localparam logic DEST_FILE = 1'b1;  // Result back to file register

  // ----------------------------------------------------------------
  // Opcodes (encoding local to this core)
  // ----------------------------------------------------------------
  localparam logic [OPC_W-1:0] OP_IDLE = 6'h00;
  localparam logic [OPC_W-1:0] OP_STORE = 6'h01;
  localparam logic [OPC_W-1:0] OP_RETINT = 6'h02;
  localparam logic [OPC_W-1:0] OP_SLEEP = 6'h03;
  localparam logic [OPC_W-1:0] OP_OR = 6'h04;
  localparam logic [OPC_W-1:0] OP_COPY = 6'h08;
  localparam logic [OPC_W-1:0] OP_INC = 6'h0a;
  localparam logic [OPC_W-1:0] OP_ROTL = 6'h0d;
  localparam logic [OPC_W-1:0] OP_LOADLIT = 6'h30;
  localparam logic [OPC_W-1:0] OP_RETLIT = 6'h34;

  // ----------------------------------------------------------------
  // Register map (byte addresses, low 12 bits decoded)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] ADDR_INSTR = 12'h000;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 12'h004;
  localparam logic [ADDR_W-1:0] ADDR_PC = 12'h008;
  localparam logic [ADDR_W-1:0] ADDR_STACK = 12'h00c;
  localparam logic [ADDR_W-1:0] ADDR_WDOG = 12'h010;
  localparam logic [ADDR_W-1:0] ADDR_WAKE = 12'h014;
  localparam logic [2:0] FILE_WIN = 3'h1;  // Bits 11:9, window 0x200
  localparam int FILE_IDX_LSB = 2;         // Word index in bits 8:2

  // ----------------------------------------------------------------
  // Status register bit positions
  // ----------------------------------------------------------------
  localparam int ST_CARRY = 8;
  localparam int ST_ZERO = 9;
  localparam int ST_EXPIRY = 10;
  localparam int ST_SLEEPFLAG = 11;
  localparam int ST_SLEEPING = 12;
  localparam int ST_BUSY = 13;
  localparam int ST_GIE = 14;
  localparam int STACK_SP_LSB = 16;        // Depth field of stack reg

  // ----------------------------------------------------------------
  // Reset values and bus codes
  // ----------------------------------------------------------------
  localparam logic EXPIRY_RST = 1'b1;
  localparam logic SLEEPFLAG_RST = 1'b1;
  localparam logic [DATA_W-1:0] WDOG_CLR = 8'h00;
  localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
  localparam logic [DATA_W-1:0] BYTE_ONE = 8'h01;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
  localparam logic HRESP_OKAY = 1'b0;
  localparam int WDOG_PRESCALE = 128;      // Core cycles per watchdog tick

  // Sequencer states
  typedef enum logic [1:0] {ST_RUN, ST_RET2, ST_SLEEP} exec_state_e;

endpackage

// ==== rtl/alu_if.sv ====
// Carrier between the core sequencer and its byte ALU.
// Assumes both ends sit in the same clock domain; purely combinational.
interface alu_if;
  import byte_op_pkg::*;

  // Operands
  logic [OPC_W-1:0] op;
  logic dest;
  logic [DATA_W-1:0] lit;
  logic [DATA_W-1:0] fileVal;
  logic [DATA_W-1:0] acc;
  logic carryIn;
  // Results
  logic [DATA_W-1:0] result;
  logic zeroOut;
  logic carryOut;
  logic writeAcc;
  logic writeFile;
  logic updZero;
  logic updCarry;

  modport core (output op, dest, lit, fileVal, acc, carryIn,
    input result, zeroOut, carryOut, writeAcc, writeFile, updZero,
    updCarry);
  modport alu (input op, dest, lit, fileVal, acc, carryIn,
    output result, zeroOut, carryOut, writeAcc, writeFile, updZero,
    updCarry);
endinterface

// ==== rtl/byte_op_alu.sv ====
// Byte ALU: result, flags and write targets for one instruction.
// Assumes operands are stable for the cycle; no state of its own.
module byte_op_alu (
  // Operands in, results out
  alu_if.alu alu
);
  import byte_op_pkg::*;

  // ----------------------------------------------------------------
  // Result and destination decode
  // ----------------------------------------------------------------
  always_comb begin
    alu.result = alu.fileVal;
    alu.carryOut = alu.carryIn;
    alu.writeAcc = 1'b0;
    alu.writeFile = 1'b0;
    alu.updZero = 1'b0;
    alu.updCarry = 1'b0;
    case (alu.op)
      OP_INC: begin
        alu.result = alu.fileVal + BYTE_ONE;
        alu.updZero = 1'b1;
      end
      OP_OR: begin
        alu.result = alu.acc | alu.fileVal;
        alu.updZero = 1'b1;
      end
      OP_COPY: begin
        alu.result = alu.fileVal;
        alu.updZero = 1'b1;
      end
      OP_ROTL: begin
        // Carry in at bit 0, old top bit out to carry
        alu.result = {alu.fileVal[DATA_W-2:0], alu.carryIn};
        alu.carryOut = alu.fileVal[DATA_W-1];
        alu.updCarry = 1'b1;
      end
      OP_STORE: begin
        alu.result = alu.acc;
        alu.writeFile = 1'b1;
      end
      OP_LOADLIT, OP_RETLIT: begin
        alu.result = alu.lit;
        alu.writeAcc = 1'b1;
      end
      default: begin
        // Idle and control opcodes touch no data
        alu.result = alu.fileVal;
      end
    endcase
    // Destination bit steers the four read-modify ops
    if (alu.op == OP_INC || alu.op == OP_OR || alu.op == OP_COPY ||
        alu.op == OP_ROTL) begin
      alu.writeFile = (alu.dest == DEST_FILE);
      alu.writeAcc = (alu.dest == DEST_ACC);
    end
    alu.zeroOut = (alu.result == BYTE_ZERO);
  end

endmodule // byte_op_alu

// ==== rtl/byte_op_instruction_exec.sv ====
// Byte-op execution core with an AHB-Lite register port.
// Assumes one AHB-Lite master, single word transfers, one clock.
// Operation
// - Increment file register, update zero flag only
// - Destination bit zero accumulator, one file
// - OR accumulator with file, update zero
// - Copy file register, zero flag from value
// - Load literal into accumulator, flags unchanged
// - Store accumulator into file, flags unchanged
// - Return literal loads accumulator, flags unchanged
// - Return literal pops stack into counter
// - Return literal takes two instruction cycles
// - Sleep stops oscillator, enters low power
// - Rotate left through carry, selected destination
// - Sleep clears watchdog, prescaler, sets expiry flag, clears entry flag
module byte_op_instruction_exec #(
  parameter int PRESCALE = byte_op_pkg::WDOG_PRESCALE
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Power state
  output logic oscRun
);
  import byte_op_pkg::*;

  localparam int PRESC_W = $clog2(PRESCALE + 1);
  localparam logic [PRESC_W-1:0] PRESC_LAST = PRESC_W'(PRESCALE - 1);
  localparam logic [PRESC_W-1:0] PRESC_CLR = '0;

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] fileMem [2**FADDR_W];  // File registers
  logic [PC_W-1:0] stackMem [2**SP_W];      // Return stack
  logic [DATA_W-1:0] acc_q;                 // Accumulator
  logic carry_q;
  logic zero_q;
  logic expiry_q;                           // watchdog_expiry_flag
  logic sleepFlag_q;                        // sleep_entry_flag
  logic gie_q;                              // global_interrupt_gate
  logic [PC_W-1:0] pc_q;
  logic [SP_W-1:0] sp_q;
  logic [DATA_W-1:0] wdog_q;                // watchdog_counter
  logic [PRESC_W-1:0] presc_q;
  exec_state_e state_q, state_d;

  // Bus pipeline
  logic wrPend_q;                           // Write data phase pending
  logic [ADDR_W-1:0] wrAddr_q;
  logic [31:0] rdData_d;
  logic [31:0] hrdata_q;
  logic oscRun_q;

  // Decode helpers
  logic addrTake;
  logic [ADDR_W-1:0] aAddr;
  logic wrInstr, wrStatus, wrPc, wrStack, wrWake, wrFile;
  logic exec;
  logic [OPC_W-1:0] opc;
  logic [FADDR_W-1:0] fSel;
  logic [PC_W-1:0] stackTop;
  logic wdTick;
  logic wdWrap;
  logic isRet;

  alu_if aluBus ();

  // ----------------------------------------------------------------
  // Address phase decode
  // ----------------------------------------------------------------
  // Any selected NONSEQ or SEQ with hready high is a taken address phase
  assign addrTake = hsel && hready && htrans[1];
  assign aAddr = haddr[ADDR_W-1:0];

  // Latch write address for the data phase
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      wrPend_q <= 1'b0;
      wrAddr_q <= ADDR_INSTR;
    end else if (hready) begin
      wrPend_q <= addrTake && hwrite;
      wrAddr_q <= aAddr;
    end
  end

  // Write strobes during the data phase
  assign wrInstr = wrPend_q && (wrAddr_q == ADDR_INSTR);
  assign wrStatus = wrPend_q && (wrAddr_q == ADDR_STATUS);
  assign wrPc = wrPend_q && (wrAddr_q == ADDR_PC);
  assign wrStack = wrPend_q && (wrAddr_q == ADDR_STACK);
  assign wrWake = wrPend_q && (wrAddr_q == ADDR_WAKE);
  assign wrFile = wrPend_q &&
    (wrAddr_q[ADDR_W-1:FADDR_W+FILE_IDX_LSB] == FILE_WIN);

  // ----------------------------------------------------------------
  // Instruction issue
  // ----------------------------------------------------------------
  // Instructions written while busy or asleep are dropped; the
  // busy and sleeping status bits tell software to retry.
  assign exec = wrInstr && (state_q == ST_RUN);
  assign opc = hwdata[INSTR_W-1:OPC_LSB];
  assign fSel = hwdata[FADDR_W-1:0];
  assign stackTop = stackMem[sp_q - SP_W'(1)];
  assign isRet = (opc == OP_RETLIT) || (opc == OP_RETINT);

  // Operands to the ALU
  assign aluBus.op = opc;
  assign aluBus.dest = hwdata[DEST_BIT];
  assign aluBus.lit = hwdata[DATA_W-1:0];
  assign aluBus.fileVal = fileMem[fSel];
  assign aluBus.acc = acc_q;
  assign aluBus.carryIn = carry_q;

  byte_op_alu uAlu (
    .alu (aluBus)
  );

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_RUN: begin
        if (exec && opc == OP_RETLIT) begin
          state_d = ST_RET2;
        end else if (exec && opc == OP_SLEEP) begin
          state_d = ST_SLEEP;
        end
      end
      ST_RET2: begin
        // Second cycle of the return, nothing new issues
        state_d = ST_RUN;
      end
      ST_SLEEP: begin
        // Woken by software or by watchdog wrap
        if (wrWake || wdWrap) begin
          state_d = ST_RUN;
        end
      end
      default: begin
        state_d = ST_RUN;
      end
    endcase
  end

  // State and oscillator enable share one decision
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      state_q <= ST_RUN;
      oscRun_q <= 1'b1;
    end else begin
      state_q <= state_d;
      oscRun_q <= (state_d != ST_SLEEP);
    end
  end

  // ----------------------------------------------------------------
  // Data path: accumulator and file registers
  // ----------------------------------------------------------------
  // Accumulator only changes on an issued instruction
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      acc_q <= BYTE_ZERO;
    end else if (exec && aluBus.writeAcc) begin
      acc_q <= aluBus.result;
    end
  end

  // File array has no reset; bus and core never write together
  always_ff @(posedge sys_clk) begin
    if (exec && aluBus.writeFile) begin
      fileMem[fSel] <= aluBus.result;
    end else if (wrFile) begin
      fileMem[wrAddr_q[FADDR_W+FILE_IDX_LSB-1:FILE_IDX_LSB]] <=
        hwdata[DATA_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      carry_q <= 1'b0;
      zero_q <= 1'b0;
    end else if (exec) begin
      if (aluBus.updZero) begin
        zero_q <= aluBus.zeroOut;
      end
      if (aluBus.updCarry) begin
        carry_q <= aluBus.carryOut;
      end
    end else if (wrStatus) begin
      // Software may seed carry and zero
      carry_q <= hwdata[ST_CARRY];
      zero_q <= hwdata[ST_ZERO];
    end
  end

  // Power flags: sleep entry sets expiry flag, clears entry flag
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      expiry_q <= EXPIRY_RST;
      sleepFlag_q <= SLEEPFLAG_RST;
    end else if (exec && opc == OP_SLEEP) begin
      expiry_q <= 1'b1;
      sleepFlag_q <= 1'b0;
    end else if (wdWrap) begin
      // Watchdog time-out shows as expiry flag low
      expiry_q <= 1'b0;
    end
  end

  // Interrupt gate
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      gie_q <= 1'b0;
    end else if (exec && opc == OP_RETINT) begin
      gie_q <= 1'b1;
    end else if (wrStatus) begin
      gie_q <= hwdata[ST_GIE];
    end
  end

  // ----------------------------------------------------------------
  // Program counter and stack
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      pc_q <= '0;
    end else if (exec) begin
      if (isRet) begin
        pc_q <= stackTop;
      end else begin
        pc_q <= pc_q + PC_W'(1);
      end
    end else if (wrPc) begin
      pc_q <= hwdata[PC_W-1:0];
    end
  end

  // Circular stack: overflow wraps, as in the small cores
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      sp_q <= '0;
    end else if (exec && isRet) begin
      sp_q <= sp_q - SP_W'(1);
    end else if (wrStack) begin
      sp_q <= sp_q + SP_W'(1);
    end
  end

  // Stack entries written only by software pushes
  always_ff @(posedge sys_clk) begin
    if (wrStack) begin
      stackMem[sp_q] <= hwdata[PC_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Watchdog counter with prescaler
  // ----------------------------------------------------------------
  assign wdTick = (presc_q == PRESC_LAST);
  assign wdWrap = wdTick && (wdog_q == {DATA_W{1'b1}});

  // Runs in sleep too: it is the only wake source besides the bus
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      presc_q <= PRESC_CLR;
      wdog_q <= WDOG_CLR;
    end else if (exec && opc == OP_SLEEP) begin
      presc_q <= PRESC_CLR;
      wdog_q <= WDOG_CLR;
    end else if (wdTick) begin
      presc_q <= PRESC_CLR;
      wdog_q <= wdog_q + BYTE_ONE;
    end else begin
      presc_q <= presc_q + PRESC_W'(1);
    end
  end

  // ----------------------------------------------------------------
  // Read path: data registered at the address phase edge
  // ----------------------------------------------------------------
  always_comb begin
    rdData_d = WORD_ZERO;
    if (aAddr == ADDR_STATUS) begin
      rdData_d[DATA_W-1:0] = acc_q;
      rdData_d[ST_CARRY] = carry_q;
      rdData_d[ST_ZERO] = zero_q;
      rdData_d[ST_EXPIRY] = expiry_q;
      rdData_d[ST_SLEEPFLAG] = sleepFlag_q;
      rdData_d[ST_SLEEPING] = (state_q == ST_SLEEP);
      rdData_d[ST_BUSY] = (state_q == ST_RET2);
      rdData_d[ST_GIE] = gie_q;
    end else if (aAddr == ADDR_PC) begin
      rdData_d[PC_W-1:0] = pc_q;
    end else if (aAddr == ADDR_STACK) begin
      rdData_d[PC_W-1:0] = stackTop;
      rdData_d[STACK_SP_LSB+SP_W-1:STACK_SP_LSB] = sp_q;
    end else if (aAddr == ADDR_WDOG) begin
      rdData_d[DATA_W-1:0] = wdog_q;
    end else if (aAddr[ADDR_W-1:FADDR_W+FILE_IDX_LSB] == FILE_WIN) begin
      rdData_d[DATA_W-1:0] =
        fileMem[aAddr[FADDR_W+FILE_IDX_LSB-1:FILE_IDX_LSB]];
    end
  end

  // Zero wait states: hreadyout stays high, response always OKAY
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      hrdata_q <= WORD_ZERO;
    end else if (addrTake && !hwrite) begin
      hrdata_q <= rdData_d;
    end
  end

  assign hrdata = hrdata_q;
  assign hreadyout = 1'b1;
  assign hresp = HRESP_OKAY;
  assign oscRun = oscRun_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  sequence s_retStart;
    exec && opc == OP_RETLIT;
  endsequence
  sequence s_twoCycles;
    (state_q == ST_RET2) ##1 (state_q == ST_RUN);
  endsequence

  property p_incAcc;
    exec && opc == OP_INC && !hwdata[DEST_BIT] |=>
      acc_q == $past(aluBus.fileVal) + BYTE_ONE &&
      zero_q == (acc_q == BYTE_ZERO) && $stable(carry_q);
  endproperty
  a_incAcc: assert property (p_incAcc) else $error("inc wrong");

  property p_destFile;
    exec && hwdata[DEST_BIT] && (opc == OP_INC || opc == OP_OR) |=>
      $stable(acc_q) && fileMem[$past(fSel)] == $past(aluBus.result);
  endproperty
  a_destFile: assert property (p_destFile) else $error("dest wrong");

  property p_orAcc;
    exec && opc == OP_OR && !hwdata[DEST_BIT] |=>
      acc_q == ($past(acc_q) | $past(aluBus.fileVal));
  endproperty
  a_orAcc: assert property (p_orAcc) else $error("or wrong");

  property p_copyZero;
    exec && opc == OP_COPY |=>
      zero_q == ($past(aluBus.fileVal) == BYTE_ZERO);
  endproperty
  a_copyZero: assert property (p_copyZero) else $error("copy z");

  property p_loadLit;
    exec && opc == OP_LOADLIT |=> acc_q == $past(hwdata[DATA_W-1:0]) &&
      $stable(zero_q) && $stable(carry_q);
  endproperty
  a_loadLit: assert property (p_loadLit) else $error("literal");

  property p_store;
    exec && opc == OP_STORE |=>
      fileMem[$past(fSel)] == $past(acc_q) && $stable(zero_q);
  endproperty
  a_store: assert property (p_store) else $error("store wrong");

  property p_retLit;
    s_retStart |=> acc_q == $past(hwdata[DATA_W-1:0]) &&
      pc_q == $past(stackTop) && sp_q == $past(sp_q) - SP_W'(1);
  endproperty
  a_retLit: assert property (p_retLit) else $error("return lit");

  property p_retCycles;
    s_retStart |=> s_twoCycles;
  endproperty
  a_retCycles: assert property (p_retCycles) else $error("ret len");

  property p_sleep;
    exec && opc == OP_SLEEP |=> !oscRun_q && wdog_q == WDOG_CLR &&
      expiry_q && !sleepFlag_q && presc_q == PRESC_CLR;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep entry");

  property p_rotl;
    exec && opc == OP_ROTL && !hwdata[DEST_BIT] |=>
      acc_q == {$past(aluBus.fileVal[DATA_W-2:0]), $past(carry_q)} &&
      carry_q == $past(aluBus.fileVal[DATA_W-1]);
  endproperty
  a_rotl: assert property (p_rotl) else $error("rotate wrong");

  property p_retInt;
    exec && opc == OP_RETINT |=> gie_q && pc_q == $past(stackTop) &&
      $stable(zero_q);
  endproperty
  a_retInt: assert property (p_retInt) else $error("ret int");

  property p_idle;
    exec && opc == OP_IDLE |=> $stable(acc_q) && $stable(sp_q) &&
      $stable(zero_q) && $stable(carry_q) && state_q == ST_RUN;
  endproperty
  a_idle: assert property (p_idle) else $error("idle changed");

endmodule // byte_op_instruction_exec

// ==== verification/test_byte_op_instruction_exec.sv ====
// Self-checking bench for the byte-op core, driven over AHB-Lite.
// Assumes zero-wait-state slave and the register map of byte_op_pkg.
module test_byte_op_instruction_exec;
  timeunit 1ns;
  timeprecision 1ps;
  import byte_op_pkg::*;

  // ------------------------------------------------------------
  // Stimulus and model state
  // ------------------------------------------------------------
  localparam int PRE = 4; // Short watchdog tick keeps the run small
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = WORD_ZERO;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = WORD_ZERO;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic oscRun;
  logic [31:0] rv; // Last read data
  logic [7:0] accM; // Expected accumulator
  logic cM; // Expected carry
  logic zM; // Expected zero
  logic gM = 1'b0; // Expected interrupt gate
  logic sM = 1'b1; // Expected sleep-entry flag
  logic eM = 1'b1; // Expected expiry flag
  int n_mismatch = 0;
  int num_checks = 0;

  // Clock, 8 ns period
  always #4 sys_clk = ~sys_clk;

  // Single slave: its hreadyout is the bus hready
  byte_op_instruction_exec #(.PRESCALE(PRE)) byte_op_instruction_exec_inst (
    .sys_clk(sys_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .oscRun(oscRun));

  // ------------------------------------------------------------
  // Bus and check tasks
  // ------------------------------------------------------------
  task automatic close_out();
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      $display("Error %s expected %h seen %h", what, exp, seen);
      n_mismatch++;
    end
  endtask

  // Bounded wait for hready sampled high at a rising edge
  task automatic rdy();
    int n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (n >= 20) begin
      n_mismatch++;
      close_out();
    end
  endtask

  // One single transfer; read data taken at the data-phase edge
  task automatic bus(logic [31:0] a, logic w, logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    rdy();
    htrans <= 2'h0;
    hwdata <= d;
    rdy();
    rv = hrdata;
  endtask

  task automatic rdchk(string what, logic [31:0] a, logic [31:0] exp);
    bus(a, 1'b0, WORD_ZERO);
    check(what, rv, exp);
  endtask

  // Whole status word against the model; busy and sleeping read low
  task automatic stat();
    bus({20'h0, ADDR_STATUS}, 1'b0, WORD_ZERO);
    check("status", rv, {17'h0, gM, 2'b00, sM, eM, zM, cM, accM});
  endtask

  function automatic logic [31:0] ins(logic [OPC_W-1:0] op, logic [7:0] lo);
    return {18'h0, op, lo};
  endfunction

  function automatic logic [31:0] fa(logic [6:0] f);
    return {20'h0, FILE_WIN, f, 2'b00};
  endfunction

  // Expected {zero, carry, result} of one register op
  function automatic logic [9:0] alu(logic [OPC_W-1:0] op,
    logic [7:0] a, logic [7:0] fv, logic c, logic z);
    logic [7:0] r;
    r = (op == OP_INC) ? fv + BYTE_ONE : (op == OP_OR) ? (a | fv) :
      (op == OP_COPY) ? fv : {fv[6:0], c};
    if (op == OP_ROTL) return {z, fv[7], r};
    return {r == BYTE_ZERO, c, r};
  endfunction

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    logic [OPC_W-1:0] ops [4];
    logic [7:0] k;
    logic [7:0] k2;
    logic [6:0] f;
    logic dst;
    logic [9:0] v;
    logic [12:0] p;
    ops = '{OP_INC, OP_OR, OP_COPY, OP_ROTL};
    void'($urandom(32'h0ade));
    repeat (6) @(posedge sys_clk);
    resetn <= 1'b1;
    rdchk("reset status", {20'h0, ADDR_STATUS}, 32'h0000_0c00);
    check("okay", 32'(hresp), WORD_ZERO);
    // Corners first: ff increment, zero copy back to itself
    for (int i = 0; i < 24; i++) begin
      k = (i == 0) ? 8'hff : (i == 2) ? 8'h00 : 8'($urandom());
      f = 7'($urandom());
      dst = (i < 4) ? DEST_FILE : 1'($urandom());
      cM = 1'($urandom());
      zM = 1'($urandom());
      bus({20'h0, ADDR_STATUS}, 1'b1, {22'h0, zM, cM, 8'h00});
      bus({20'h0, ADDR_INSTR}, 1'b1, ins(OP_LOADLIT, k));
      accM = k;
      stat();
      bus({20'h0, ADDR_INSTR}, 1'b1, ins(OP_STORE, {1'b0, f}));
      rdchk("file", fa(f), 32'(k));
      k2 = 8'($urandom());
      bus({20'h0, ADDR_INSTR}, 1'b1, ins(OP_LOADLIT, k2));
      accM = k2;
      v = alu(ops[i % 4], k2, k, cM, zM);
      bus({20'h0, ADDR_INSTR}, 1'b1, ins(ops[i % 4], {dst, f}));
      {zM, cM} = v[9:8];
      if (dst == DEST_ACC) accM = v[7:0];
      stat();
      rdchk("dest", fa(f), 32'((dst == DEST_FILE) ? v[7:0] : k));
    end
    // Return with literal; the read right after it sees the busy slot
    p = 13'($urandom());
    k = 8'($urandom());
    bus({20'h0, ADDR_STACK}, 1'b1, 32'(p));
    bus({20'h0, ADDR_INSTR}, 1'b1, ins(OP_RETLIT, k));
    accM = k;
    bus({20'h0, ADDR_STATUS}, 1'b0, WORD_ZERO);
    check("busy", 32'(rv[ST_BUSY]), 32'h1);
    rdchk("pc", {20'h0, ADDR_PC}, 32'(p));
    stat();
    // Idle only steps the counter
    p = p + 13'h1;
    bus({20'h0, ADDR_INSTR}, 1'b1, ins(OP_IDLE, 8'h00));
    rdchk("pc", {20'h0, ADDR_PC}, 32'(p));
    stat();
    // Return from interrupt opens the gate
    p = 13'($urandom());
    bus({20'h0, ADDR_STACK}, 1'b1, 32'(p));
    bus({20'h0, ADDR_INSTR}, 1'b1, ins(OP_RETINT, 8'h00));
    gM = 1'b1;
    rdchk("pc", {20'h0, ADDR_PC}, 32'(p));
    stat();
    check("gate", 32'(rv[ST_GIE]), 32'h1);
    // Sleep: watchdog read first, before its first tick
    bus({20'h0, ADDR_INSTR}, 1'b1, ins(OP_SLEEP, 8'h00));
    sM = 1'b0;
    rdchk("wdog", {20'h0, ADDR_WDOG}, 32'(WDOG_CLR));
    check("osc", 32'(oscRun), WORD_ZERO);
    bus({20'h0, ADDR_STATUS}, 1'b0, WORD_ZERO);
    check("sleep bits", 32'(rv[12:10]), 32'h5);
    bus({20'h0, ADDR_WAKE}, 1'b1, WORD_ZERO);
    @(posedge sys_clk);
    check("osc", 32'(oscRun), 32'h1);
    rdchk("unmapped", 32'h0000_0100, WORD_ZERO);
    // Second sleep: only the watchdog wrap, 256 ticks on, wakes it
    bus({20'h0, ADDR_INSTR}, 1'b1, ins(OP_SLEEP, 8'h00));
    for (int n = 0; n < 1100; n++) begin
      @(posedge sys_clk);
      if (oscRun === 1'b1) break;
    end
    check("wdog wake", 32'(oscRun), 32'h1);
    eM = 1'b0;
    stat();
    close_out();
  end
endmodule // test_byte_op_instruction_exec
